// *** hw/tsee_top.sv ***
`timescale 1ns/100ps
// Functional notes
// [R1] temperature sampled continuously, no request needed
// [R2] host reads latest temperature any time
// [R3] open-drain active-low alarm from sensor config
// [R4] alarm modes: interrupt, comparator, critical-only
// [R5] interrupt alarm held until clear-event write
// [R6] comparator alarm releases when condition ends
// [R7] critical limit always compared as comparator
// [R8] critical-only: assert above limit, hysteresis release
// [R9] store never touches the alarm pin
// [R10] 512 bytes, four 128-byte blocks, lower three write-protectable
// [R11] blocks hold config, module, user data
// [R12] block 2 lower half reads zero
// [R13] lower 384 bytes preloaded, top free
// [R14] reversible protection over bytes 0 to 383
// [R15] bus target clocked by serial clock
// [R16] reachable only over the two-wire bus
// [R17] protected writes ignored, contents unchanged
module tsee_top #(
  parameter int CONV_CYC = tsee_pkg::CONV_CYCLES
) (
  // core clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // converter result, core domain
  input  wire logic [7:0] meas_code,
  // two-wire bus, scl is the link clock
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // alarm pin, open drain
  input  wire logic       event_n_i,
  output logic            event_n_o,
  output logic            event_n_oe
);
  import tsee_pkg::*;

  localparam int CW = $clog2(CONV_CYC);

  // core domain
  logic [CW-1:0] conv_cnt_r;
  logic          conv_tick_r;
  logic [7:0]    temp_r, upper_r, crit_r, hyst_r;
  logic [1:0]    mode_r;
  logic [4:0]    core_q;
  logic          sda_q, scl_q, cfg_q, clr_q, ack_q;
  logic          scl_d_r, sda_d_r, start_tog_r;
  logic          cfg_seen_r, clr_seen_r, upper_d_r;
  logic          crit_act_r, event_r, alarm_nxt;
  logic          crit_over, crit_under, upper_over, clr_pulse, evt_set;
  logic          pub_tog_r;
  logic [9:0]    pub_word_r;
  // link domain
  logic          st1_r, st2_r, st_seen_r, start_seen;
  logic          pub_q, ack_s_r;
  logic [9:0]    stat_s_r;
  logic [1:0]    mode_s_r;
  logic [7:0]    upper_s_r, crit_s_r, hyst_s_r;
  logic          cfg_tog_s_r, clr_tog_s_r, wp_r;
  tsee_state_t   state_r;
  logic [2:0]    cnt_r;
  logic [7:0]    sh_r, tx_r, ptr_r, rx_byte, rd_byte, sens_rd, ee_rdata;
  logic          page_r, sel_ee_r, rd_r, last_bit;
  logic          dev_hit_s, dev_hit_e, wr_stb, ptr_stb, rd_load, dev_stb;
  logic          sda_oe_r, sda_o_r, event_n_oe_r, event_n_o_r;

  assign sda_oe     = sda_oe_r;
  assign sda_o      = sda_o_r;
  assign event_n_oe = event_n_oe_r;
  assign event_n_o  = event_n_o_r;

  // ****************************************
  // core side crossings
  // ****************************************
  tsee_sync #(.W(5)) u_sync_core (
    .clk    (core_clk),
    .rstn   (rstn),
    .d      ({ack_s_r, clr_tog_s_r, cfg_tog_s_r, scl, sda_i}),
    .sync_r (core_q)
  );

  assign sda_q = core_q[0];
  assign scl_q = core_q[1];
  assign cfg_q = core_q[2];
  assign clr_q = core_q[3];
  assign ack_q = core_q[4];

  // start seen here, handed to the link side as a toggle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_r     <= 1'b1;
      sda_d_r     <= 1'b1;
      start_tog_r <= 1'b0;
    end else begin
      scl_d_r <= scl_q;
      sda_d_r <= sda_q;
      if (scl_q && scl_d_r && sda_d_r && !sda_q) begin
        start_tog_r <= ~start_tog_r;
      end
    end
  end

  // config word is static for many cycles after its toggle flips
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_seen_r <= 1'b0;
      mode_r     <= MODE_RST;
      upper_r    <= UPPER_RST;
      crit_r     <= CRIT_RST;
      hyst_r     <= HYST_RST;
    end else begin
      cfg_seen_r <= cfg_q;
      if (cfg_q != cfg_seen_r) begin
        mode_r  <= mode_s_r;
        upper_r <= upper_s_r;
        crit_r  <= crit_s_r;
        hyst_r  <= hyst_s_r;
      end
    end
  end

  // ****************************************
  // conversion
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      conv_cnt_r  <= '0;
      conv_tick_r <= 1'b0;
    end else if (conv_cnt_r == CW'(CONV_CYC - 1)) begin
      conv_cnt_r  <= '0;
      conv_tick_r <= 1'b1;
    end else begin
      conv_cnt_r  <= conv_cnt_r + 1'b1;
      conv_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      temp_r <= TEMP_RST;
    end else if (conv_tick_r) begin
      temp_r <= meas_code; // [R1]
    end
  end

  // ****************************************
  // alarm
  // ****************************************
  assign crit_over  = t_over(temp_r, crit_r);
  assign crit_under = t_under(temp_r, crit_r, hyst_r);
  assign upper_over = t_over(temp_r, upper_r);
  assign clr_pulse  = clr_q != clr_seen_r;
  assign evt_set    = (mode_r == MODE_INT) && upper_over && !upper_d_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      crit_act_r <= 1'b0;
    end else if (crit_over) begin
      crit_act_r <= 1'b1; // [R7] [R8]
    end else if (crit_under) begin
      crit_act_r <= 1'b0; // [R8]
    end
  end

  // set wins over a clear landing in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clr_seen_r <= 1'b0;
      upper_d_r  <= 1'b0;
      event_r    <= 1'b0;
    end else begin
      clr_seen_r <= clr_q;
      upper_d_r  <= upper_over;
      if (evt_set) begin
        event_r <= 1'b1;
      end else if (clr_pulse) begin
        event_r <= 1'b0; // [R5]
      end
    end
  end

  always_comb begin
    unique case (mode_r)
      MODE_INT:  alarm_nxt = event_r | crit_act_r; // [R4] [R5]
      MODE_CMP:  alarm_nxt = upper_over | crit_act_r; // [R6]
      MODE_CRIT: alarm_nxt = crit_act_r; // [R8]
      default:   alarm_nxt = crit_act_r;
    endcase
  end

  // pin pulled low only from sensor state, store has no path here
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      event_n_oe_r <= 1'b0;
      event_n_o_r  <= 1'b0;
    end else begin
      event_n_oe_r <= alarm_nxt; // [R3] [R9]
      event_n_o_r  <= 1'b0;
    end
  end

  // ****************************************
  // status publish to the link side
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pub_tog_r  <= 1'b0;
      pub_word_r <= {2'b00, TEMP_RST};
    end else if (pub_tog_r == ack_q) begin
      pub_word_r <= {event_n_oe_r, event_r, temp_r}; // [R2]
      pub_tog_r  <= ~pub_tog_r;
    end
  end

  // ****************************************
  // link side crossings
  // ****************************************
  // first stage on the falling edge so a start is known by the second data bit
  always_ff @(negedge scl or negedge rstn) begin
    if (!rstn) begin
      st1_r <= 1'b0;
    end else begin
      st1_r <= start_tog_r;
    end
  end

  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      st2_r <= 1'b0;
    end else begin
      st2_r <= st1_r;
    end
  end

  assign start_seen = st2_r != st_seen_r;

  tsee_sync #(.W(1)) u_sync_link (
    .clk    (scl),
    .rstn   (rstn),
    .d      (pub_tog_r),
    .sync_r (pub_q)
  );

  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      ack_s_r  <= 1'b0;
      stat_s_r <= {2'b00, TEMP_RST};
    end else if (pub_q != ack_s_r) begin
      stat_s_r <= pub_word_r; // [R2]
      ack_s_r  <= pub_q;
    end
  end

  // ****************************************
  // bus target, sampled on rising scl
  // ****************************************
  assign rx_byte   = {sh_r[6:0], sda_i};
  assign last_bit  = cnt_r == 3'h7;
  assign dev_hit_s = rx_byte[7:1] == SENS_ADDR;
  assign dev_hit_e = rx_byte[7:2] == EE_ADDR[6:1];
  assign dev_stb   = !start_seen && (state_r == ST_DEVADR) && last_bit;
  assign ptr_stb   = !start_seen && (state_r == ST_PTR) && last_bit;
  assign wr_stb    = !start_seen && (state_r == ST_WDATA) && last_bit;
  assign rd_load   = !start_seen && (((state_r == ST_ACK_DEV) && rd_r) ||
                                     ((state_r == ST_ACK_RD) && !sda_i));

  // shifts on every rise, so the bit taken before a start is known survives
  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      sh_r <= 8'h00;
    end else begin
      sh_r <= rx_byte;
    end
  end

  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      st_seen_r <= 1'b0;
      state_r   <= ST_IDLE;
      cnt_r     <= 3'h0;
      sel_ee_r  <= 1'b0;
      rd_r      <= 1'b0;
    end else if (start_seen) begin
      // start known only at the second rise: bits 7 and 6 are in the shifter
      st_seen_r <= st2_r; // [R15]
      state_r   <= ST_DEVADR;
      cnt_r     <= 3'h2;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          cnt_r <= 3'h0;
        end
        ST_DEVADR: begin
          cnt_r <= cnt_r + 1'b1;
          if (last_bit) begin
            state_r  <= (dev_hit_s || dev_hit_e) ? ST_ACK_DEV : ST_IDLE;
            sel_ee_r <= dev_hit_e;
            rd_r     <= rx_byte[0];
          end
        end
        ST_PTR, ST_WDATA: begin
          cnt_r <= cnt_r + 1'b1;
          if (last_bit) begin
            state_r <= (state_r == ST_PTR) ? ST_ACK_PTR : ST_ACK_WR;
          end
        end
        ST_ACK_DEV: begin
          cnt_r   <= 3'h0;
          state_r <= rd_r ? ST_RDATA : ST_PTR;
        end
        ST_ACK_PTR, ST_ACK_WR: begin
          cnt_r   <= 3'h0;
          state_r <= ST_WDATA;
        end
        ST_RDATA: begin
          cnt_r <= cnt_r + 1'b1;
          if (last_bit) begin
            state_r <= ST_ACK_RD;
          end
        end
        ST_ACK_RD: begin
          cnt_r   <= 3'h0;
          state_r <= sda_i ? ST_IDLE : ST_RDATA;
        end
      endcase
    end
  end

  // pointer advances after every byte moved, wraps inside its half
  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      ptr_r  <= 8'h00;
      page_r <= 1'b0;
    end else begin
      if (dev_stb && dev_hit_e) begin
        page_r <= rx_byte[1];
      end
      if (ptr_stb) begin
        ptr_r <= rx_byte;
      end else if (wr_stb || rd_load) begin
        ptr_r <= ptr_r + 8'h01;
      end
    end
  end

  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      tx_r <= 8'h00;
    end else if (rd_load) begin
      tx_r <= rd_byte;
    end else if (state_r == ST_RDATA) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // ****************************************
  // sensor registers, link side
  // ****************************************
  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      mode_s_r    <= MODE_RST;
      upper_s_r   <= UPPER_RST;
      crit_s_r    <= CRIT_RST;
      hyst_s_r    <= HYST_RST;
      wp_r        <= WP_RST;
      cfg_tog_s_r <= 1'b0;
      clr_tog_s_r <= 1'b0;
    end else if (wr_stb && !sel_ee_r) begin
      unique case (ptr_r[2:0])
        REG_CFG: begin
          mode_s_r    <= rx_byte[CFG_MODE_LSB +: 2]; // [R4]
          cfg_tog_s_r <= ~cfg_tog_s_r;
        end
        REG_STAT: begin
          if (rx_byte[STAT_CLR_BIT]) begin
            clr_tog_s_r <= ~clr_tog_s_r; // [R5]
          end
        end
        REG_UPPER: begin
          upper_s_r   <= rx_byte;
          cfg_tog_s_r <= ~cfg_tog_s_r;
        end
        REG_CRIT: begin
          crit_s_r    <= rx_byte;
          cfg_tog_s_r <= ~cfg_tog_s_r;
        end
        REG_HYST: begin
          hyst_s_r    <= rx_byte;
          cfg_tog_s_r <= ~cfg_tog_s_r;
        end
        REG_WP: begin
          wp_r <= rx_byte[WP_BIT]; // [R14]
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    sens_rd = 8'h00;
    unique case (ptr_r[2:0])
      REG_CFG:   sens_rd = {6'h00, mode_s_r};
      REG_STAT: begin
        sens_rd[STAT_EVT_BIT] = stat_s_r[8];
        sens_rd[STAT_ALM_BIT] = stat_s_r[9];
      end
      REG_UPPER: sens_rd = upper_s_r;
      REG_CRIT:  sens_rd = crit_s_r;
      REG_HYST:  sens_rd = hyst_s_r;
      REG_TEMP:  sens_rd = stat_s_r[7:0]; // [R2]
      REG_WP:    sens_rd = {7'h00, wp_r};
      default:   sens_rd = 8'h00;
    endcase
  end

  assign rd_byte = sel_ee_r ? ee_rdata : sens_rd;

  // only path into the store is the two-wire target
  tsee_store u_store (
    .clk   (scl),
    .rstn  (rstn),
    .we    (wr_stb && sel_ee_r), // [R16]
    .addr  ({page_r, ptr_r}),
    .wdata (rx_byte),
    .wp    (wp_r),
    .rdata (ee_rdata)
  );

  // ****************************************
  // data line drive, on falling scl
  // ****************************************
  always_ff @(negedge scl or negedge rstn) begin
    if (!rstn) begin
      sda_oe_r <= 1'b0;
      sda_o_r  <= 1'b0;
    end else begin
      sda_o_r <= 1'b0;
      unique case (state_r)
        ST_ACK_DEV, ST_ACK_PTR, ST_ACK_WR: sda_oe_r <= 1'b1; // [R15]
        ST_RDATA: sda_oe_r <= !tx_r[7];
        default:  sda_oe_r <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_crit_enter;
    !crit_act_r ##1 crit_over;
  endsequence

  sequence s_int_pending;
    (mode_r == MODE_INT) && event_r && !clr_pulse;
  endsequence

  property p_crit_set;
    @(posedge core_clk) disable iff (!rstn) s_crit_enter |=> crit_act_r ##1 event_n_oe_r;
  endproperty
  a_crit_set: assert property (p_crit_set) else $error("critical alarm late"); // [R7]

  property p_crit_hyst;
    @(posedge core_clk) disable iff (!rstn)
      crit_act_r && !crit_under |=> crit_act_r;
  endproperty
  a_crit_hyst: assert property (p_crit_hyst) else $error("critical dropped early"); // [R8]

  property p_crit_release;
    @(posedge core_clk) disable iff (!rstn) crit_act_r && crit_under |=> !crit_act_r;
  endproperty
  a_crit_release: assert property (p_crit_release) else $error("critical stuck"); // [R8]

  property p_crit_only;
    @(posedge core_clk) disable iff (!rstn)
      (mode_r == MODE_CRIT) && !crit_act_r |=> !event_n_oe_r;
  endproperty
  a_crit_only: assert property (p_crit_only) else $error("alarm without critical"); // [R8]

  property p_cmp_release;
    @(posedge core_clk) disable iff (!rstn)
      (mode_r == MODE_CMP) && !upper_over && !crit_act_r |=> !event_n_oe_r;
  endproperty
  a_cmp_release: assert property (p_cmp_release) else $error("comparator held"); // [R6]

  property p_int_hold;
    @(posedge core_clk) disable iff (!rstn) s_int_pending |=> event_r && event_n_oe_r;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt lost"); // [R5]

  property p_int_clear;
    @(posedge core_clk) disable iff (!rstn) event_r && clr_pulse && !evt_set |=> !event_r;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("clear ignored"); // [R5]

  property p_conv;
    @(posedge core_clk) disable iff (!rstn) conv_tick_r |=> temp_r == $past(meas_code);
  endproperty
  a_conv: assert property (p_conv) else $error("sample not taken"); // [R1]

  property p_pub;
    @(posedge scl) disable iff (!rstn)
      pub_q != ack_s_r |=> stat_s_r == $past(pub_word_r);
  endproperty
  a_pub: assert property (p_pub) else $error("status not refreshed"); // [R2]
endmodule

// *** hw/tsee_pkg.sv ***
package tsee_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CORE_CLK_MHZ = 50;
  localparam int CONV_TIME_US = 1000;
  localparam int CONV_CYCLES  = CONV_TIME_US * CORE_CLK_MHZ;
  localparam int LINK_MAX_KHZ = 1000;

  // ****************************************
  // bus addresses
  // ****************************************
  localparam logic [6:0] SENS_ADDR = 7'h18;
  // lsb of the store address picks the 256-byte half
  localparam logic [6:0] EE_ADDR   = 7'h50;

  // ****************************************
  // presence-detect store layout
  // ****************************************
  localparam int EE_BYTES   = 512;
  localparam int EE_BLOCK   = 128;
  localparam int EE_RSV_LO  = 256;
  localparam int EE_RSV_HI  = 319;
  localparam int EE_PROT_HI = 383;
  localparam logic [7:0] EE_FILL  = 8'h5A;
  localparam logic [7:0] EE_BLANK = 8'hFF;

  // ****************************************
  // sensor registers and fields
  // ****************************************
  localparam logic [2:0] REG_CFG   = 3'h0;
  localparam logic [2:0] REG_STAT  = 3'h1;
  localparam logic [2:0] REG_UPPER = 3'h2;
  localparam logic [2:0] REG_CRIT  = 3'h3;
  localparam logic [2:0] REG_HYST  = 3'h4;
  localparam logic [2:0] REG_TEMP  = 3'h5;
  localparam logic [2:0] REG_WP    = 3'h6;
  localparam int CFG_MODE_LSB  = 0;
  localparam int STAT_CLR_BIT  = 0;
  localparam int STAT_EVT_BIT  = 0;
  localparam int STAT_ALM_BIT  = 1;
  localparam int WP_BIT        = 0;
  localparam logic [1:0] MODE_INT  = 2'h0;
  localparam logic [1:0] MODE_CMP  = 2'h1;
  localparam logic [1:0] MODE_CRIT = 2'h2;
  localparam logic [1:0] MODE_RST  = MODE_INT;
  localparam logic [7:0] UPPER_RST = 8'h50;
  localparam logic [7:0] CRIT_RST  = 8'h5F;
  localparam logic [7:0] HYST_RST  = 8'h02;
  localparam logic [7:0] TEMP_RST  = 8'h00;
  localparam logic       WP_RST    = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEVADR, ST_ACK_DEV, ST_PTR, ST_ACK_PTR,
    ST_WDATA, ST_ACK_WR, ST_RDATA, ST_ACK_RD
  } tsee_state_t;

  function automatic logic t_over(input logic [7:0] t, input logic [7:0] l);
    return $signed(t) > $signed(l);
  endfunction

  function automatic logic t_under(input logic [7:0] t, input logic [7:0] c,
                                   input logic [7:0] h);
    logic signed [9:0] lim;
    lim = $signed({{2{c[7]}}, c}) - $signed({2'b00, h});
    return $signed({{2{t[7]}}, t}) < lim;
  endfunction

  function automatic logic ee_reserved(input logic [8:0] a);
    return (int'(a) >= EE_RSV_LO) && (int'(a) <= EE_RSV_HI);
  endfunction

  // factory content stand-in; the real image is loaded at production
  function automatic logic [7:0] ee_init(input int a);
    if (a > EE_PROT_HI) return EE_BLANK;
    if ((a >= EE_RSV_LO) && (a <= EE_RSV_HI)) return 8'h00;
    return a[7:0] ^ EE_FILL;
  endfunction

endpackage

// *** hw/tsee_sync.sv ***
`timescale 1ns/100ps
module tsee_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] sync_r
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end
endmodule

// *** hw/tsee_store.sv ***
`timescale 1ns/100ps
module tsee_store (
  // link clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // write port
  input  wire logic       we,
  input  wire logic [8:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wp,
  // read port
  output logic      [7:0] rdata
);
  import tsee_pkg::*;

  logic [7:0] mem_r [EE_BYTES];
  logic       wr_ok;
  logic       blocked_r;
  logic [8:0] held_addr_r;
  logic [7:0] held_r;

  // ****************************************
  // storage
  // ****************************************
  // protection covers the three factory blocks only
  assign wr_ok = !ee_reserved(addr) && (!wp || (int'(addr) > EE_PROT_HI)); // [R14] [R17]

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < EE_BYTES; i++) begin
        mem_r[i] <= ee_init(i); // [R13]
      end
    end else if (we && wr_ok) begin
      mem_r[addr] <= wdata; // [R10]
    end
  end

  assign rdata = ee_reserved(addr) ? 8'h00 : mem_r[addr]; // [R12] [R11]

  // ****************************************
  // checks
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blocked_r   <= 1'b0;
      held_addr_r <= 9'h000;
      held_r      <= 8'h00;
    end else begin
      blocked_r   <= we && !wr_ok;
      held_addr_r <= addr;
      held_r      <= mem_r[addr];
    end
  end

  property p_protect;
    @(posedge clk) disable iff (!rstn) blocked_r |-> mem_r[held_addr_r] == held_r;
  endproperty
  a_protect: assert property (p_protect) else $error("protected byte changed"); // [R17]

  property p_reserved;
    @(posedge clk) disable iff (!rstn) ee_reserved(addr) |-> mem_r[addr] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte nonzero"); // [R12]
endmodule

// *** bench/tsee_host.sv ***
`timescale 1ns/100ps
module tsee_host (
  // bus wires
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // ****
  // frame primitives
  // ****
  // clock stands high between frames
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // start or repeated start, 360 ns before first rise
  task automatic start();
    // odd delay keeps link edges off the core clock's edges
    #25 sda_pull = 1'b0;
    #20 scl = 1'b1;
    #200 sda_pull = 1'b1;
    #320 scl = 1'b0;
  endtask
  // eight bits msb first, ninth bit is the ack slot
  task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic ack);
    for (int i = 7; i >= -1; i--) begin
      #20 sda_pull = (i >= 0) ? ~d[i] : ~last;
      #20 scl = 1'b1;
      #20 if (i >= 0) q[i] = sda; else ack = ~sda;
      #20 scl = 1'b0;
    end
  endtask
  task automatic stop();
    #20 sda_pull = 1'b1;
    #20 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #200;
  endtask
endmodule

// *** bench/tsee_top_tb.sv ***
`timescale 1ns/100ps
module tsee_top_tb;
  import tsee_pkg::*;
  logic       core_clk;
  logic       rstn;
  logic [7:0] meas_code;
  wire        scl;
  wire        sda_pull;
  wire        sda_o;
  wire        sda_oe;
  wire        event_n_o;
  wire        event_n_oe;
  wire        sda_w;
  wire        ev_w;
  logic [7:0] exp_q[$];
  logic [7:0] got_v;
  logic [7:0] q;
  logic [7:0] v;
  string      got_n;
  event       got_e;
  int         fail_count;
  int         n_checks;
  int         cyc;
  integer     seed;
  // ****
  // wires and instances
  // ****
  // pulled-up open-drain lines
  assign sda_w = !(sda_pull || (sda_oe && !sda_o));
  assign ev_w  = !(event_n_oe && !event_n_o);
  tsee_host host (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));
  tsee_top #(.CONV_CYC(16)) uut (.core_clk(core_clk), .rstn(rstn), .meas_code(meas_code),
    .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .event_n_i(ev_w),
    .event_n_o(event_n_o), .event_n_oe(event_n_oe));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ****
  // tasks
  // ****
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [6:0] ee(input logic [8:0] a);
    return {EE_ADDR[6:1], a[8]};
  endfunction
  task automatic wr(input logic [6:0] dv, input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    host.start();
    host.byte_x({dv, 1'b0}, 1'b1, r, a);
    host.byte_x(p, 1'b1, r, a);
    host.byte_x(d, 1'b1, r, a);
    host.stop();
  endtask
  task automatic rd(input logic [6:0] dv, input logic [7:0] p, output logic [7:0] r);
    logic a;
    host.start();
    host.byte_x({dv, 1'b0}, 1'b1, r, a);
    host.byte_x(p, 1'b1, r, a);
    host.start();
    host.byte_x({dv, 1'b1}, 1'b1, r, a);
    host.byte_x(8'hFF, 1'b1, r, a);
    host.stop();
  endtask
  // note the expectation, then hand the result to the monitor
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    exp_q.push_back(e);
    got_v = g;
    got_n = nm;
    -> got_e;
    #1;
  endtask
  task automatic echk(input string nm, input logic [8:0] a, input logic [7:0] e);
    logic [7:0] r;
    rd(ee(a), a[7:0], r);
    chk(nm, e, r);
  endtask
  // three conversion periods so the new value has landed
  task automatic tset(input logic [7:0] t);
    @(posedge core_clk);
    #2 meas_code = t;
    repeat (48) @(posedge core_clk);
  endtask
  task automatic achk(input logic e);
    chk("alarm", {7'h00, e}, {7'h00, event_n_oe});
  endtask
  initial forever begin
    @(got_e);
    n_checks++;
    if (got_v !== exp_q[0]) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", got_n, exp_q[0], got_v);
    end
    void'(exp_q.pop_front());
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    rstn      = 1'b0;
    meas_code = 8'h00;
    seed      = 79;
    repeat (5) @(posedge core_clk);
    #2 rstn = 1'b1;
    repeat (8) @(posedge core_clk);
    echk("img_b0", 9'h005, 8'h5F);
    echk("img_b1", 9'h0A0, 8'hFA);
    echk("img_rsv", 9'h100, 8'h00);
    echk("img_mfg", 9'h17F, 8'h25);
    echk("img_user", 9'h1FF, 8'hFF);
    wr(ee(9'h005), 8'h05, 8'hAA);
    echk("wp_lo", 9'h005, 8'h5F);
    wr(ee(9'h180), 8'h80, 8'h3C);
    echk("user_wr", 9'h180, 8'h3C);
    wr(SENS_ADDR, {5'h00, REG_WP}, 8'h00);
    wr(ee(9'h005), 8'h05, 8'hAA);
    echk("unprot", 9'h005, 8'hAA);
    wr(ee(9'h105), 8'h05, 8'h77);
    echk("rsv_wr", 9'h105, 8'h00);
    achk(1'b0);
    $display("test store done");
    wr(SENS_ADDR, {5'h00, REG_UPPER}, 8'h30);
    tset(8'h40);
    achk(1'b1);
    tset(8'h20);
    achk(1'b1);
    // latched event and asserted pin both show in status
    rd(SENS_ADDR, {5'h00, REG_STAT}, q);
    chk("stat", 8'h03, q);
    wr(SENS_ADDR, {5'h00, REG_STAT}, 8'h01);
    repeat (10) @(posedge core_clk);
    achk(1'b0);
    wr(SENS_ADDR, {5'h00, REG_CFG}, {6'h00, MODE_CMP});
    tset(8'h40);
    achk(1'b1);
    tset(8'h20);
    achk(1'b0);
    wr(SENS_ADDR, {5'h00, REG_CFG}, {6'h00, MODE_CRIT});
    tset(8'h40);
    achk(1'b0);
    tset(8'h60);
    achk(1'b1);
    tset(8'h5E);
    achk(1'b1);
    tset(8'h5C);
    achk(1'b0);
    $display("test alarm done");
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      tset(v);
      rd(SENS_ADDR, {5'h00, REG_TEMP}, q);
      chk("temp", v, q);
    end
    $display("test temp done");
    report_and_stop();
  end
endmodule
